// *** design/fsrw_regs.svh ***
// register offsets, field positions, reset values and timing in nanoseconds
`ifndef FSRW_REGS_SVH
`define FSRW_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FSRW_CTRL_OFS 4'h0
`define FSRW_STAT_OFS 4'h4
`define FSRW_IRQ_STAT_OFS 4'h8
`define FSRW_IRQ_MASK_OFS 4'hc
// ----------------------------------------
// control field positions
// ----------------------------------------
`define FSRW_CTRL_RWW_CLR_BIT 0
`define FSRW_CTRL_APP_LOCK_BIT 1
`define FSRW_CTRL_BOOT_LOCK_BIT 2
// ----------------------------------------
// status field positions
// ----------------------------------------
`define FSRW_STAT_BUSY_BIT 0
`define FSRW_STAT_RWW_BUSY_BIT 1
`define FSRW_STAT_HALT_BIT 2
// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define FSRW_IRQ_DONE_BIT 0
`define FSRW_IRQ_REFUSE_BIT 1
`define FSRW_IRQ_W 2
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define FSRW_LOCK_RST 1'b0
`define FSRW_PROG_TIME_NS 4000
`define FSRW_CLK_NS 8
`endif

// *** design/fsrw_pkg.sv ***
// types shared by the self-program access control block
package fsrw_pkg;
  typedef enum logic [2:0] {
    FSRW_IDLE = 3'b001,
    FSRW_PROG = 3'b010,
    FSRW_DONE = 3'b100
  } fsrw_state_t;
  typedef enum logic [1:0] {
    FSRW_ACC_NONE = 2'h0,
    FSRW_ACC_READ = 2'h1,
    FSRW_ACC_WRITE = 2'h2
  } fsrw_acc_t;
endpackage

// *** design/fsrw_region_cmp.sv ***
// page address classification into sections and regions
`timescale 1ns/100ps
module fsrw_region_cmp import fsrw_pkg::*; #(
  parameter int PAGE_W = 9,
  parameter int NO_READ_WHILE_WRITE_REGION_PAGE = 448
) (
  input wire logic [PAGE_W-1:0] i_page,
  input wire logic [PAGE_W-1:0] i_boot_start,
  output logic o_in_boot,
  output logic o_in_no_read_while_write_region
);
  localparam logic [PAGE_W-1:0] NO_READ_WHILE_WRITE_REGION_START = PAGE_W'(NO_READ_WHILE_WRITE_REGION_PAGE);
  logic [PAGE_W-1:0] boot_start_lim;
  always_comb begin
    // boot section never starts below the no-rww limit
    boot_start_lim = (i_boot_start < NO_READ_WHILE_WRITE_REGION_START) ? NO_READ_WHILE_WRITE_REGION_START : i_boot_start;
    o_in_boot = (i_page >= boot_start_lim);
    o_in_no_read_while_write_region = (i_page >= NO_READ_WHILE_WRITE_REGION_START);
  end
endmodule // fsrw_region_cmp

// *** design/fsrw_avmm_slave.sv ***
// avalon-mm register access decoder
`timescale 1ns/100ps
`include "fsrw_regs.svh"
module fsrw_avmm_slave import fsrw_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  output logic o_waitrequest,
  output logic o_acc_read,
  output logic o_acc_write
);
  typedef struct packed {
    logic ack;
  } fsrw_av_st_t;
  fsrw_av_st_t st_reg;
  fsrw_av_st_t st_next;
  always_comb begin
    st_next = st_reg;
    // one wait cycle, then accept
    st_next.ack = (i_read | i_write) & ~st_reg.ack;
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_waitrequest = (i_read | i_write) & ~st_reg.ack;
  assign o_acc_read = i_read & st_reg.ack;
  assign o_acc_write = i_write & st_reg.ack;
endmodule // fsrw_avmm_slave

// *** design/fsrw_flash_ctrl.sv ***
// self-program access control with rww blocking and core halt
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "fsrw_regs.svh"
// What this block does
// - program only from boot loader section
// - boot loader may target any page
// - separate lock bits per section
// - rww target keeps core fetching
// - no_read_while_write_region target halts core whole operation
// - classify by target page, not fetch
// - boot section lies inside no_read_while_write_region region
// - rww region reads not served while blocked
// - busy flag reads one while blocked
module fsrw_flash_ctrl import fsrw_pkg::*; #(
  parameter int PAGE_W = 9,
  parameter int NO_READ_WHILE_WRITE_REGION_PAGE = 448,
  parameter int PROG_CYC = (`FSRW_PROG_TIME_NS + `FSRW_CLK_NS - 1) / `FSRW_CLK_NS
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic o_waitrequest,
  output logic [31:0] o_readdata,
  input wire logic [PAGE_W-1:0] i_boot_size_fuses,
  input wire logic i_spm_req,
  input wire logic [PAGE_W-1:0] i_spm_page,
  input wire logic [PAGE_W-1:0] i_fetch_page,
  input wire logic i_fetch_req,
  output logic o_fetch_ok,
  output logic o_core_halt,
  output logic o_prog_start,
  output logic [PAGE_W-1:0] o_prog_page,
  output logic o_rw_region_busy_flag,
  output logic o_irq
);
  localparam int CNT_W = $clog2(PROG_CYC + 1);
  typedef struct packed {
    fsrw_state_t state;
    logic [CNT_W-1:0] cnt;
    logic no_read_while_write_region_op;
    logic rww_busy;
    logic app_lock;
    logic boot_lock;
    logic [`FSRW_IRQ_W-1:0] irq_stat;
    logic [`FSRW_IRQ_W-1:0] irq_mask;
    logic start;
    logic [PAGE_W-1:0] page;
    logic [31:0] rdata;
    logic [CNT_W:0] mon;
  } fsrw_st_t;
  fsrw_st_t st_reg;
  fsrw_st_t st_next;
  logic acc_read;
  logic acc_write;
  logic tgt_boot;
  logic tgt_no_read_while_write_region;
  logic fetch_boot;
  logic fetch_no_read_while_write_region;
  logic allowed;
  logic [`FSRW_IRQ_W-1:0] ev;
  // ----------------------------------------
  // submodules
  // ----------------------------------------
  fsrw_avmm_slave u_bus (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_address(i_address),
    .i_read(i_read),
    .i_write(i_write),
    .o_waitrequest(o_waitrequest),
    .o_acc_read(acc_read),
    .o_acc_write(acc_write)
  );
  fsrw_region_cmp #(.PAGE_W(PAGE_W), .NO_READ_WHILE_WRITE_REGION_PAGE(NO_READ_WHILE_WRITE_REGION_PAGE)) u_tgt (
    .i_page(i_spm_page),
    .i_boot_start(i_boot_size_fuses),
    .o_in_boot(tgt_boot),
    .o_in_no_read_while_write_region(tgt_no_read_while_write_region)
  );
  fsrw_region_cmp #(.PAGE_W(PAGE_W), .NO_READ_WHILE_WRITE_REGION_PAGE(NO_READ_WHILE_WRITE_REGION_PAGE)) u_fetch (
    .i_page(i_fetch_page),
    .i_boot_start(i_boot_size_fuses),
    .o_in_boot(fetch_boot),
    .o_in_no_read_while_write_region(fetch_no_read_while_write_region)
  );
  // ----------------------------------------
  // request admission
  // ----------------------------------------
  always_comb begin
    // only from boot code, target lock by its own section
    allowed = fetch_boot & (tgt_boot ? ~st_reg.boot_lock : ~st_reg.app_lock);
  end
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    ev = '0;
    st_next.start = 1'b0;
    // cycles spent in the current operation, for the length checks
    st_next.mon = (st_reg.state == FSRW_PROG) ? st_reg.mon + (CNT_W+1)'(1) : '0;
    case (st_reg.state)
      FSRW_IDLE: begin
        if (i_spm_req) begin
          if (allowed) begin
            st_next.state = FSRW_PROG;
            st_next.cnt = CNT_W'(PROG_CYC);
            st_next.no_read_while_write_region_op = tgt_no_read_while_write_region;
            st_next.rww_busy = 1'b1;
            st_next.start = 1'b1;
            st_next.page = i_spm_page;
          end else begin
            ev[`FSRW_IRQ_REFUSE_BIT] = 1'b1;
          end
        end
      end
      FSRW_PROG: begin
        if (st_reg.cnt <= CNT_W'(1)) begin
          st_next.state = FSRW_DONE;
        end else begin
          st_next.cnt = st_reg.cnt - CNT_W'(1);
        end
      end
      FSRW_DONE: begin
        st_next.state = FSRW_IDLE;
        st_next.no_read_while_write_region_op = 1'b0;
        ev[`FSRW_IRQ_DONE_BIT] = 1'b1;
      end
      default: begin
        st_next.state = FSRW_IDLE;
      end
    endcase
    // register writes
    if (acc_write) begin
      if (i_address == `FSRW_CTRL_OFS) begin
        if (i_writedata[`FSRW_CTRL_RWW_CLR_BIT] && st_reg.state == FSRW_IDLE) begin
          st_next.rww_busy = 1'b0;
        end
        st_next.app_lock = i_writedata[`FSRW_CTRL_APP_LOCK_BIT];
        st_next.boot_lock = i_writedata[`FSRW_CTRL_BOOT_LOCK_BIT];
      end else if (i_address == `FSRW_IRQ_STAT_OFS) begin
        st_next.irq_stat = st_reg.irq_stat & ~i_writedata[`FSRW_IRQ_W-1:0];
      end else if (i_address == `FSRW_IRQ_MASK_OFS) begin
        st_next.irq_mask = i_writedata[`FSRW_IRQ_W-1:0];
      end
    end
    // set wins over clear
    st_next.irq_stat = st_next.irq_stat | ev;
    // register reads, captured in the wait cycle so data stands at acceptance
    if (i_read && !acc_read) begin
      st_next.rdata = '0;
      if (i_address == `FSRW_CTRL_OFS) begin
        st_next.rdata[`FSRW_CTRL_APP_LOCK_BIT] = st_reg.app_lock;
        st_next.rdata[`FSRW_CTRL_BOOT_LOCK_BIT] = st_reg.boot_lock;
      end else if (i_address == `FSRW_STAT_OFS) begin
        st_next.rdata[`FSRW_STAT_BUSY_BIT] = (st_reg.state != FSRW_IDLE);
        st_next.rdata[`FSRW_STAT_RWW_BUSY_BIT] = st_reg.rww_busy;
        st_next.rdata[`FSRW_STAT_HALT_BIT] = o_core_halt;
      end else if (i_address == `FSRW_IRQ_STAT_OFS) begin
        st_next.rdata[`FSRW_IRQ_W-1:0] = st_reg.irq_stat;
      end else if (i_address == `FSRW_IRQ_MASK_OFS) begin
        st_next.rdata[`FSRW_IRQ_W-1:0] = st_reg.irq_mask;
      end
    end
  end
  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '{state: FSRW_IDLE, cnt: '0, no_read_while_write_region_op: 1'b0, rww_busy: 1'b0,
                  app_lock: `FSRW_LOCK_RST, boot_lock: `FSRW_LOCK_RST, irq_stat: '0,
                  irq_mask: '0, start: 1'b0, page: '0, rdata: '0, mon: '0};
    end else begin
      st_reg <= st_next;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  wire op_active = (st_reg.state == FSRW_PROG);
  assign o_core_halt = op_active & st_reg.no_read_while_write_region_op;
  assign o_fetch_ok = i_fetch_req & ~o_core_halt & (fetch_no_read_while_write_region | ~st_reg.rww_busy);
  assign o_rw_region_busy_flag = st_reg.rww_busy;
  assign o_prog_start = st_reg.start;
  assign o_prog_page = st_reg.page;
  assign o_readdata = st_reg.rdata;
  assign o_irq = |(st_reg.irq_stat & st_reg.irq_mask);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_app_refused: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_reg.state == FSRW_IDLE && i_spm_req && !fetch_boot) |=> !o_prog_start)
    else $error("program started from application code");
  a_no_read_while_write_region_halt: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_prog_start && st_reg.no_read_while_write_region_op) |-> o_core_halt [*8])
    else $error("core not halted through no_read_while_write_region operation");
  a_rww_nohalt: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (op_active && !st_reg.no_read_while_write_region_op) |-> !o_core_halt)
    else $error("core halted during rww operation");
  a_rww_blocked: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (op_active && !fetch_no_read_while_write_region) |-> !o_fetch_ok)
    else $error("rww fetch served during programming");
  a_busy_flag: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_prog_start |-> o_rw_region_busy_flag throughout (op_active [*4]))
    else $error("busy flag low while rww blocked");
  a_target_class: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_prog_start |-> (st_reg.no_read_while_write_region_op == ($past(i_spm_page) >= PAGE_W'(NO_READ_WHILE_WRITE_REGION_PAGE))))
    else $error("operation classified by wrong address");
  a_boot_no_read_while_write_region: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    tgt_boot |-> tgt_no_read_while_write_region)
    else $error("boot section outside no_read_while_write_region region");
  a_lock_refuse: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_reg.state == FSRW_IDLE && i_spm_req && tgt_boot && st_reg.boot_lock)
    |=> !o_prog_start ##1 $rose(st_reg.irq_stat[`FSRW_IRQ_REFUSE_BIT]) or
    st_reg.irq_stat[`FSRW_IRQ_REFUSE_BIT])
    else $error("locked boot section was programmed");
  // ----------------------------------------
  // operation length
  // ----------------------------------------
  a_op_length: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    op_active |-> (st_reg.mon < (CNT_W+1)'(PROG_CYC)))
    else $error("operation runs too long");
  a_op_end: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $fell(op_active) |-> (st_reg.mon == (CNT_W+1)'(PROG_CYC)))
    else $error("operation ended early");
  a_cnt_live: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    op_active |-> (st_reg.cnt != '0))
    else $error("operation counter empty while active");
  // ----------------------------------------
  // halt and fetch
  // ----------------------------------------
  a_halt_only_no_read_while_write_region: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_core_halt |-> (op_active && st_reg.no_read_while_write_region_op))
    else $error("core halted outside no_read_while_write_region operation");
  a_halt_no_fetch: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_core_halt |-> !o_fetch_ok)
    else $error("fetch served while core halted");
  a_idle_no_halt: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_reg.state == FSRW_IDLE) |-> !o_core_halt)
    else $error("core halted while idle");
  a_no_read_while_write_region_served: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (op_active && !st_reg.no_read_while_write_region_op && fetch_no_read_while_write_region && i_fetch_req) |-> o_fetch_ok)
    else $error("no_read_while_write_region fetch refused during rww operation");
  // ----------------------------------------
  // admission and start
  // ----------------------------------------
  a_admit: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_reg.state == FSRW_IDLE && i_spm_req && allowed) |=> o_prog_start)
    else $error("allowed request not started");
  a_refuse_event: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_reg.state == FSRW_IDLE && i_spm_req && !allowed)
    |=> st_reg.irq_stat[`FSRW_IRQ_REFUSE_BIT])
    else $error("refused request left no event");
  a_app_lock: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_reg.state == FSRW_IDLE && i_spm_req && !tgt_boot && st_reg.app_lock)
    |=> !o_prog_start)
    else $error("locked application section was programmed");
  a_start_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_prog_start |=> !o_prog_start)
    else $error("start pulse longer than one cycle");
  a_start_active: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_prog_start |-> op_active)
    else $error("start outside operation");
  a_page_taken: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_prog_start |-> (o_prog_page == $past(i_spm_page)))
    else $error("accepted page differs from request");
  // ----------------------------------------
  // busy flag, events and registers
  // ----------------------------------------
  a_busy_start: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_prog_start |-> o_rw_region_busy_flag)
    else $error("busy flag low at start");
  a_busy_clear: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $fell(o_rw_region_busy_flag) |-> $past(acc_write))
    else $error("busy flag cleared without software");
  a_done_event: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $fell(op_active) |=> st_reg.irq_stat[`FSRW_IRQ_DONE_BIT])
    else $error("finished operation left no event");
  a_lock_write: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (acc_write && i_address == `FSRW_CTRL_OFS)
    |=> (st_reg.app_lock == $past(i_writedata[`FSRW_CTRL_APP_LOCK_BIT])))
    else $error("application lock not written");
  a_rdata_hold: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !(i_read && o_waitrequest) |=> $stable(o_readdata))
    else $error("read data changed outside a read");
endmodule // fsrw_flash_ctrl

// *** testbench/fsrw_core_model.sv ***
// behavioural core running the boot loader, issuing program requests and fetches
`timescale 1ns/100ps
module fsrw_core_model #(
  parameter int PAGE_W = 9,
  parameter int NO_READ_WHILE_WRITE_REGION_PAGE = 448
) (
  input wire logic i_sys_clk,
  input wire logic i_go,
  input wire logic [PAGE_W-1:0] i_target,
  input wire logic [PAGE_W-1:0] i_exec_page,
  input wire logic i_rude,
  input wire logic i_core_halt,
  input wire logic i_rw_busy,
  output logic o_spm_req,
  output logic [PAGE_W-1:0] o_spm_page,
  output logic [PAGE_W-1:0] o_fetch_page,
  output logic o_fetch_req
);
  // ----------------------------------------
  // program request, one-cycle pulse
  // ----------------------------------------
  initial begin
    o_spm_req = 1'b0;
    o_spm_page = '0;
  end
  always @(posedge i_sys_clk) begin
    o_spm_req <= i_go && !i_core_halt;
    o_spm_page <= i_go ? i_target : ~o_spm_page;
  end
  // ----------------------------------------
  // fetch: none while halted, none from rww region while busy unless told
  // ----------------------------------------
  assign o_fetch_page = i_exec_page;
  assign o_fetch_req = !i_core_halt &&
    (i_rude || !(i_exec_page < NO_READ_WHILE_WRITE_REGION_PAGE && i_rw_busy));
endmodule // fsrw_core_model

// *** testbench/fsrw_flash_ctrl_bench.sv ***
// self-checking bench for the self-program access control block
`timescale 1ns/100ps
`include "fsrw_regs.svh"
module fsrw_flash_ctrl_bench import fsrw_pkg::*; ;
  localparam int PC = 8;
  localparam int NP = 448;
  logic clk, rstn, rd, wr, wreq, go, rude, sreq, freq, fok, halt, pstart, busy, irq;
  logic [3:0] adr;
  logic [31:0] wd, rdat, q;
  logic [8:0] fuse, tgt, exec, spage, fpage, ppage;
  logic st;
  int n_mismatch, comparisons, n;
  fsrw_flash_ctrl #(.PAGE_W(9), .NO_READ_WHILE_WRITE_REGION_PAGE(NP), .PROG_CYC(PC)) u_dut (
    .i_sys_clk(clk), .i_resetn(rstn), .i_address(adr), .i_read(rd), .i_write(wr),
    .i_writedata(wd), .o_waitrequest(wreq), .o_readdata(rdat),
    .i_boot_size_fuses(fuse), .i_spm_req(sreq), .i_spm_page(spage),
    .i_fetch_page(fpage), .i_fetch_req(freq), .o_fetch_ok(fok), .o_core_halt(halt),
    .o_prog_start(pstart), .o_prog_page(ppage), .o_rw_region_busy_flag(busy),
    .o_irq(irq));
  fsrw_core_model #(.PAGE_W(9), .NO_READ_WHILE_WRITE_REGION_PAGE(NP)) u_core (
    .i_sys_clk(clk), .i_go(go), .i_target(tgt), .i_exec_page(exec), .i_rude(rude),
    .i_core_halt(halt), .i_rw_busy(busy), .o_spm_req(sreq), .o_spm_page(spage),
    .o_fetch_page(fpage), .o_fetch_req(freq));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (wreq === 1'b0) begin
        q = rdat;
        break;
      end
    end
    if (k == 20) begin
      n_mismatch++;
      tally_and_finish();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic store_program_memory_op(input logic [8:0] t, input logic [8:0] e);
    exec <= e;
    tgt <= t;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    st = 1'b0;
    repeat (6) begin
      @(posedge clk);
      if (pstart === 1'b1) st = 1'b1;
      if (st) break;
    end
  endtask
  task automatic wait_idle();
    for (n = 0; n < 50; n++) begin
      bus(1'b0, `FSRW_STAT_OFS, 32'h0);
      if (q[`FSRW_STAT_BUSY_BIT] === 1'b0) break;
    end
    if (n == 50) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    bus(1'b0, `FSRW_STAT_OFS, 32'h0);
    cmp(q, 32'h0, "status after reset");
    bus(1'b0, `FSRW_CTRL_OFS, 32'h0);
    cmp(q, 32'h0, "locks after reset");
    bus(1'b1, 4'h2, 32'hffffffff);
    bus(1'b0, 4'h2, 32'h0);
    cmp(q, 32'h0, "unmapped read");
  endtask
  task automatic t_app_refuse();
    bus(1'b1, `FSRW_IRQ_MASK_OFS, 32'h3);
    store_program_memory_op(9'h014, 9'h00a);
    cmp(st, 1'b0, "start from application");
    bus(1'b0, `FSRW_IRQ_STAT_OFS, 32'h0);
    cmp(q, 32'h2, "refuse event");
    cmp(irq, 1'b1, "irq raised");
    bus(1'b1, `FSRW_IRQ_MASK_OFS, 32'h1);
    cmp(irq, 1'b0, "irq masked");
    bus(1'b1, `FSRW_IRQ_STAT_OFS, 32'h2);
    bus(1'b0, `FSRW_IRQ_STAT_OFS, 32'h0);
    cmp(q, 32'h0, "refuse cleared");
  endtask
  task automatic t_rww();
    store_program_memory_op(9'h014, 9'h1f4);
    cmp(st, 1'b1, "rww start");
    cmp(ppage, 9'h014, "page taken");
    cmp(halt, 1'b0, "no halt on rww");
    cmp(fok, 1'b1, "boot fetch served");
    cmp(busy, 1'b1, "busy flag set");
    exec <= 9'h014;
    rude <= 1'b1;
    @(posedge clk);
    cmp(fok, 1'b0, "rww fetch blocked");
    rude <= 1'b0;
    exec <= 9'h1f4;
    wait_idle();
    cmp(busy, 1'b1, "busy held after op");
    cmp(irq, 1'b1, "done irq");
    bus(1'b1, `FSRW_IRQ_STAT_OFS, 32'h1);
    bus(1'b1, `FSRW_CTRL_OFS, 32'h1);
    cmp(busy, 1'b0, "busy cleared");
    cmp(irq, 1'b0, "irq cleared");
  endtask
  task automatic t_no_read_while_write_region(input logic [8:0] t);
    store_program_memory_op(t, 9'h1f4);
    cmp(st, 1'b1, "no_read_while_write_region start");
    n = 0;
    while (halt === 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
    end
    cmp(n >= PC && n <= PC + 2, 1'b1, "halt length");
    wait_idle();
    bus(1'b1, `FSRW_IRQ_STAT_OFS, 32'h3);
    bus(1'b1, `FSRW_CTRL_OFS, 32'h1);
  endtask
  task automatic t_locks();
    bus(1'b1, `FSRW_CTRL_OFS, 32'h2);
    store_program_memory_op(9'h014, 9'h1f4);
    cmp(st, 1'b0, "app locked");
    t_no_read_while_write_region(9'h1f0);
    bus(1'b1, `FSRW_CTRL_OFS, 32'h4);
    store_program_memory_op(9'h1f0, 9'h1f4);
    cmp(st, 1'b0, "boot locked");
    store_program_memory_op(9'h014, 9'h1f4);
    cmp(st, 1'b1, "app open");
    wait_idle();
    bus(1'b1, `FSRW_CTRL_OFS, 32'h1);
    bus(1'b1, `FSRW_IRQ_STAT_OFS, 32'h3);
  endtask
  // ----------------------------------------
  // clock, reset, sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    {rd, wr, go, rude} = 4'h0;
    adr = 4'h0;
    wd = 32'h0;
    fuse = 9'h1e0;
    tgt = 9'h0;
    exec = 9'h1f4;
    n_mismatch = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_app_refuse();
    t_rww();
    t_no_read_while_write_region(9'h1cc);
    t_no_read_while_write_region(9'h1f4);
    t_locks();
    tally_and_finish();
  end
endmodule // fsrw_flash_ctrl_bench
